// File: pkg/csr_consts.vh
// Purpose: constants for the processor segment register set
// Assumes: 25 MHz clock, status bit n sits at vector index 15-n
// Notes: selector codes shared by write and read ports
//
// Operation
// - code base holds segment first word
// - counter stays within code base..limit
// - counter escape raises bounds violation
// - code limit holds segment last word
// - data limit holds lowest user word
// - data base holds global area start
// - marker link points at marker word
// - return checks marker; privileged may go lower
// - memory top checked within base..ceiling; privileged may go lower
// - cached count three bits, 0 to 4
// - stack head is memory top plus count
// - ceiling is last stack word
// - index register, program accessible, 16 bits
// - status word holds segment, indicators, modes
// - mask bit one enables its group
// - mask load privileged, mask read always
// - privileged ops, uncallable calls refused in user
// - status bit 0 mode, privileged change only
// - uncallable bit comes from program label
// - bit1 irq enable privileged, bit2 traps any
// - bits 4..7 overflow, carry, condition code
`ifndef CSR_CONSTS_VH
`define CSR_CONSTS_VH

// =====================================================
// Register selectors
`define CSR_SEL_CODE_BASE 4'h0
`define CSR_SEL_IC 4'h1
`define CSR_SEL_CODE_LIMIT 4'h2
`define CSR_SEL_DATA_LIMIT 4'h3
`define CSR_SEL_DATA_BASE 4'h4
`define CSR_SEL_MARKER 4'h5
`define CSR_SEL_SMTOP 4'h6
`define CSR_SEL_CACHED 4'h7
`define CSR_SEL_CEILING 4'h8
`define CSR_SEL_INDEX 4'h9
`define CSR_SEL_STATUS 4'hA
`define CSR_SEL_MASK 4'hB
`define CSR_SEL_HEAD 4'hC

// =====================================================
// Status word field positions (bit n at index 15-n)
`define CSR_ST_MODE 15
`define CSR_ST_IRQEN 14
`define CSR_ST_TRAPEN 13
`define CSR_ST_RSTK 12
`define CSR_ST_OVF 11
`define CSR_ST_CARRY 10
`define CSR_ST_CC_HI 9
`define CSR_ST_CC_LO 8
`define CSR_ST_SEG_HI 7

// =====================================================
// Reset values and limits
`define CSR_STATUS_RST 16'h8000
`define CSR_WORD_RST 16'h0000
`define CSR_CACHED_RST 3'h0
`define CSR_CACHED_MAX 3'h4
`define CSR_CEIL_SPARE 13

`endif

// File: hdl/csr_regset.v
// Purpose: architectural segment, index, status and mask registers
// Assumes: one execution unit drives all request strobes
// Notes: violations and refusals are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "csr_consts.vh"

module csr_regset #(
  parameter W = 16
) (
  input wire clk, // 25 MHz clock
  input wire rstn, // async reset, active low
  input wire wr_en, // set-registers write strobe
  input wire [3:0] wr_sel, // register selector
  input wire [W-1:0] wr_data, // write value
  input wire rd_en, // read strobe
  input wire [3:0] rd_sel, // read selector
  input wire ic_ld, // new counter value strobe
  input wire [W-1:0] ic_next, // proposed counter value
  input wire ret_chk, // return restores marker link
  input wire [W-1:0] ret_marker, // marker value to restore
  input wire ld_mask, // load mask instruction
  input wire [W-1:0] stack_head_in, // top of stack word
  input wire priv_req, // privileged instruction attempt
  input wire call_req, // procedure call attempt
  input wire call_label_unc, // uncallable bit of label
  input wire ind_we, // indicator update strobe
  input wire ovf_in, // new overflow
  input wire carry_in, // new carry
  input wire [1:0] cc_in, // new condition code
  input wire rstk_set, // right stack op pending set
  input wire rstk_clr, // right stack op pending clear
  output reg [W-1:0] rd_data_q, // read result
  output reg rd_valid_q, // read result valid
  output reg [W-1:0] ic_q, // instruction counter
  output reg [W-1:0] status_q, // status word
  output reg [W-1:0] irq_grp_en_q, // group enables
  output reg bounds_viol_q, // bounds violation pulse
  output reg priv_ok_q, // privileged attempt granted
  output reg priv_refused_q // privileged attempt refused
);

  // ===================================================
  // Storage
  reg [W-1:0] code_base_q;
  reg [W-1:0] code_limit_q;
  reg [W-1:0] data_limit_q;
  reg [W-1:0] data_base_q;
  reg [W-1:0] marker_link_q;
  reg [W-1:0] stack_memory_top_q;
  reg [2:0] cached_top_count_q;
  reg [W-1:0] stack_ceiling_q;
  reg [W-1:0] index_reg_q;
  reg [W-1:0] interrupt_mask_q;

  wire priv;
  wire [W-1:0] stack_head;
  wire ic_in_seg;
  wire ret_in_stack;
  wire sm_in_stack;
  wire wr_sm;
  wire wr_cnt;
  wire wr_st;
  wire wr_mk;
  wire cnt_ok;
  wire mask_go;
  wire call_go;
  wire call_bad;
  wire ic_go;
  wire wr_ic;
  wire wr_ic_ok;

  reg [W-1:0] status_d;
  reg [W-1:0] rd_d;
  reg viol_d;
  reg [W-1:0] mask_d;

  assign priv = status_q[`CSR_ST_MODE];

  // ===================================================
  // Logical stack head, never stored
  assign stack_head = stack_memory_top_q
    + {{(W-3){1'b0}}, cached_top_count_q};

  // ===================================================
  // Bounds checks
  assign ic_in_seg = (ic_next >= code_base_q)
    && (ic_next <= code_limit_q);

  // Privileged code may drop the marker below data base
  assign ret_in_stack = (priv || (ret_marker >= data_base_q))
    && (ret_marker <= stack_ceiling_q);

  // Check on memory top, not head: ceiling keeps spare words
  assign sm_in_stack = (priv || (wr_data >= data_base_q))
    && (wr_data <= stack_ceiling_q);

  assign wr_sm = wr_en && (wr_sel == `CSR_SEL_SMTOP);
  assign wr_cnt = wr_en && (wr_sel == `CSR_SEL_CACHED);
  assign wr_st = wr_en && (wr_sel == `CSR_SEL_STATUS);
  assign wr_mk = wr_en && (wr_sel == `CSR_SEL_MARKER);
  assign wr_ic = wr_en && (wr_sel == `CSR_SEL_IC);

  // Set-registers may not park the counter outside its segment
  assign wr_ic_ok = (wr_data >= code_base_q)
    && (wr_data <= code_limit_q);

  // Counts above four would misplace the head
  assign cnt_ok = (wr_data[2:0] <= `CSR_CACHED_MAX)
    && (wr_data[W-1:3] == {(W-3){1'b0}});

  assign mask_go = ld_mask && priv;
  assign call_bad = call_req && call_label_unc && !priv;
  assign call_go = call_req && !call_bad;
  assign ic_go = ic_ld && ic_in_seg;

  // ===================================================
  // Violation sources share one path
  always @* begin
    viol_d = 1'b0;
    if (ic_ld && !ic_in_seg) begin
      viol_d = 1'b1;
    end
    if (wr_ic && !wr_ic_ok) begin
      viol_d = 1'b1;
    end
    if (ret_chk && !ret_in_stack) begin
      viol_d = 1'b1;
    end
    if (wr_sm && !sm_in_stack) begin
      viol_d = 1'b1;
    end
  end

  // ===================================================
  // Status word next value
  always @* begin
    status_d = status_q;
    if (ind_we) begin
      status_d[`CSR_ST_OVF] = ovf_in;
      status_d[`CSR_ST_CARRY] = carry_in;
      status_d[`CSR_ST_CC_HI:`CSR_ST_CC_LO] = cc_in;
    end
    if (rstk_clr) begin
      status_d[`CSR_ST_RSTK] = 1'b0;
    end
    if (wr_st) begin
      // Traps, indicators and segment are free in any mode
      status_d[`CSR_ST_TRAPEN] = wr_data[`CSR_ST_TRAPEN];
      status_d[`CSR_ST_OVF] = wr_data[`CSR_ST_OVF];
      status_d[`CSR_ST_CARRY] = wr_data[`CSR_ST_CARRY];
      status_d[`CSR_ST_CC_HI:`CSR_ST_CC_LO] =
        wr_data[`CSR_ST_CC_HI:`CSR_ST_CC_LO];
      status_d[`CSR_ST_SEG_HI:0] = wr_data[`CSR_ST_SEG_HI:0];
      if (priv) begin
        status_d[`CSR_ST_MODE] = wr_data[`CSR_ST_MODE];
        status_d[`CSR_ST_IRQEN] = wr_data[`CSR_ST_IRQEN];
        status_d[`CSR_ST_RSTK] = wr_data[`CSR_ST_RSTK];
      end
    end
    // Hardware set beats any clear in the same cycle
    if (rstk_set) begin
      status_d[`CSR_ST_RSTK] = 1'b1;
    end
  end

  // ===================================================
  // Mask next value, shared by register and group enables
  always @* begin
    mask_d = interrupt_mask_q;
    if (mask_go) begin
      mask_d = stack_head_in;
    end else if (wr_en && (wr_sel == `CSR_SEL_MASK) && priv) begin
      mask_d = wr_data;
    end
  end

  // ===================================================
  // Read mux, one cycle latency
  always @* begin
    case (rd_sel)
      `CSR_SEL_CODE_BASE: begin
        rd_d = code_base_q;
      end
      `CSR_SEL_IC: begin
        rd_d = ic_q;
      end
      `CSR_SEL_CODE_LIMIT: begin
        rd_d = code_limit_q;
      end
      `CSR_SEL_DATA_LIMIT: begin
        rd_d = data_limit_q;
      end
      `CSR_SEL_DATA_BASE: begin
        rd_d = data_base_q;
      end
      `CSR_SEL_MARKER: begin
        rd_d = marker_link_q;
      end
      `CSR_SEL_SMTOP: begin
        rd_d = stack_memory_top_q;
      end
      `CSR_SEL_CACHED: begin
        rd_d = {{(W-3){1'b0}}, cached_top_count_q};
      end
      `CSR_SEL_CEILING: begin
        rd_d = stack_ceiling_q;
      end
      `CSR_SEL_INDEX: begin
        rd_d = index_reg_q;
      end
      `CSR_SEL_STATUS: begin
        rd_d = status_q;
      end
      `CSR_SEL_MASK: begin
        rd_d = interrupt_mask_q;
      end
      `CSR_SEL_HEAD: begin
        rd_d = stack_head;
      end
      default: begin
        rd_d = `CSR_WORD_RST;
      end
    endcase
  end

  // ===================================================
  // Segment and data registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      code_base_q <= `CSR_WORD_RST;
      code_limit_q <= `CSR_WORD_RST;
      data_limit_q <= `CSR_WORD_RST;
      data_base_q <= `CSR_WORD_RST;
      stack_ceiling_q <= `CSR_WORD_RST;
      index_reg_q <= `CSR_WORD_RST;
    end else if (wr_en) begin
      case (wr_sel)
        `CSR_SEL_CODE_BASE: begin
          code_base_q <= wr_data;
        end
        `CSR_SEL_CODE_LIMIT: begin
          code_limit_q <= wr_data;
        end
        `CSR_SEL_DATA_LIMIT: begin
          data_limit_q <= wr_data;
        end
        `CSR_SEL_DATA_BASE: begin
          data_base_q <= wr_data;
        end
        `CSR_SEL_CEILING: begin
          stack_ceiling_q <= wr_data;
        end
        `CSR_SEL_INDEX: begin
          index_reg_q <= wr_data;
        end
        default: begin
        end
      endcase
    end
  end

  // ===================================================
  // Counter: an out-of-segment value is never taken
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ic_q <= `CSR_WORD_RST;
    end else if (ic_go) begin
      ic_q <= ic_next;
    end else if (wr_ic && wr_ic_ok) begin
      ic_q <= wr_data;
    end
  end

  // ===================================================
  // Stack registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      marker_link_q <= `CSR_WORD_RST;
      stack_memory_top_q <= `CSR_WORD_RST;
      cached_top_count_q <= `CSR_CACHED_RST;
    end else begin
      // Return restore wins over a plain write
      if (ret_chk && ret_in_stack) begin
        marker_link_q <= ret_marker;
      end else if (wr_mk) begin
        marker_link_q <= wr_data;
      end
      if (wr_sm && sm_in_stack) begin
        stack_memory_top_q <= wr_data;
      end
      if (wr_cnt && cnt_ok) begin
        cached_top_count_q <= wr_data[2:0];
      end
    end
  end

  // ===================================================
  // Status, mask and event outputs
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= `CSR_STATUS_RST;
      interrupt_mask_q <= `CSR_WORD_RST;
      rd_data_q <= `CSR_WORD_RST;
      rd_valid_q <= 1'b0;
      bounds_viol_q <= 1'b0;
      priv_ok_q <= 1'b0;
      priv_refused_q <= 1'b0;
    end else begin
      status_q <= status_d;
      interrupt_mask_q <= mask_d;
      rd_valid_q <= rd_en;
      if (rd_en) begin
        rd_data_q <= rd_d;
      end
      bounds_viol_q <= viol_d;
      priv_ok_q <= (priv_req && priv) || call_go || mask_go;
      priv_refused_q <= (priv_req && !priv) || call_bad
        || (ld_mask && !priv);
    end
  end

  // ===================================================
  // Per-group interrupt enables, gated by status bit 1
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : grp
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          irq_grp_en_q[g] <= 1'b0;
        end else begin
          irq_grp_en_q[g] <= status_d[`CSR_ST_IRQEN] & mask_d[g];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// File: testbench/csr_regset_asserts.sv
// Purpose: port-level checks for csr_regset
// Assumes: status bit n sits at vector index 15-n
// Notes: single clock domain, bound at file foot
`timescale 1ns/1ps
`default_nettype none
// ====================================
// Checker
module csr_regset_asserts #(
  parameter W = 16
) (
  input wire logic clk, // clock
  input wire logic rstn, // reset, active low
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  input wire logic ic_ld, // counter load
  input wire logic [W-1:0] ic_next, // counter value
  input wire logic ret_chk, // return check
  input wire logic ld_mask, // mask load
  input wire logic [W-1:0] stack_head_in, // stack top
  input wire logic priv_req, // privileged attempt
  input wire logic call_req, // call attempt
  input wire logic call_label_unc, // uncallable bit
  input wire logic ind_we, // indicator strobe
  input wire logic ovf_in, // overflow in
  input wire logic carry_in, // carry in
  input wire logic [1:0] cc_in, // condition code in
  input wire logic rd_valid_q, // read valid
  input wire logic [W-1:0] ic_q, // counter
  input wire logic [W-1:0] status_q, // status word
  input wire logic [W-1:0] irq_grp_en_q, // group enables
  input wire logic bounds_viol_q, // violation
  input wire logic priv_ok_q, // granted
  input wire logic priv_refused_q // refused
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_ic_load_outcome: assert property (
    ic_ld |=> bounds_viol_q || ic_q == $past(ic_next))
    else $error("counter load neither taken nor refused");
  a_ic_viol_hold: assert property (
    ic_ld && !ret_chk && !wr_en ##1 bounds_viol_q |-> $stable(ic_q))
    else $error("counter moved on violation");
  a_viol_cause: assert property (
    bounds_viol_q |-> $past(ic_ld || ret_chk || wr_en))
    else $error("violation without a cause");
  a_rd_answer: assert property (
    rd_en |=> rd_valid_q) else $error("read not answered");
  a_user_stays: assert property (
    !status_q[15] |=> !status_q[15]) else $error("user raised mode");
  a_irq_en_keep: assert property (
    !status_q[15] |=> $stable(status_q[14]))
    else $error("irq enable changed in user mode");
  a_priv_grant: assert property (
    priv_req |=> priv_ok_q == $past(status_q[15])
    && priv_refused_q != $past(status_q[15]))
    else $error("privileged attempt misjudged");
  a_call_check: assert property (
    call_req |=> priv_refused_q == $past(call_label_unc && !status_q[15]))
    else $error("call misjudged");
  a_mask_user: assert property (
    ld_mask && !status_q[15] |=> priv_refused_q && $stable(irq_grp_en_q))
    else $error("user mask load not refused");
  a_mask_load: assert property (
    ld_mask && status_q[15:14] == 2'b11 && !wr_en
    |=> irq_grp_en_q == $past(stack_head_in))
    else $error("mask load not seen on enables");
  a_ind_write: assert property (
    ind_we && !wr_en |=> status_q[11:8] == $past({ovf_in, carry_in, cc_in}))
    else $error("indicators not updated");

  c_refused: cover property (priv_refused_q);
  c_viol: cover property (bounds_viol_q);
  c_mask: cover property (ld_mask && status_q[15]);
endmodule

bind csr_regset csr_regset_asserts #(.W(W)) u_chk (
  .clk(clk),
  .rstn(rstn),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .ic_ld(ic_ld),
  .ic_next(ic_next),
  .ret_chk(ret_chk),
  .ld_mask(ld_mask),
  .stack_head_in(stack_head_in),
  .priv_req(priv_req),
  .call_req(call_req),
  .call_label_unc(call_label_unc),
  .ind_we(ind_we),
  .ovf_in(ovf_in),
  .carry_in(carry_in),
  .cc_in(cc_in),
  .rd_valid_q(rd_valid_q),
  .ic_q(ic_q),
  .status_q(status_q),
  .irq_grp_en_q(irq_grp_en_q),
  .bounds_viol_q(bounds_viol_q),
  .priv_ok_q(priv_ok_q),
  .priv_refused_q(priv_refused_q)
);
`default_nettype wire

// File: testbench/test_cpu_segment_register_set.sv
// Purpose: self-checking bench for csr_regset
// Assumes: pulses answered one cycle after the strobe
// Notes: reads noted in a queue, compared by a monitor
`timescale 1ns/1ps
`default_nettype none
`include "csr_consts.vh"
module test_cpu_segment_register_set;
  logic clk = 0, rstn = 0, wr_en = 0, rd_en = 0, ic_ld = 0, ret_chk = 0;
  logic ld_mask = 0, priv_req = 0, call_req = 0, call_label_unc = 0;
  logic ind_we = 0, ovf_in = 0, carry_in = 0, rstk_set = 0, rstk_clr = 0;
  logic [1:0] cc_in = 0;
  logic [3:0] wr_sel = 0, rd_sel = 0;
  logic [15:0] wr_data = 0, ic_next = 0, ret_marker = 0, stack_head_in = 0;
  wire [15:0] rd_data_q, ic_q, status_q, irq_grp_en_q;
  wire rd_valid_q, bounds_viol_q, priv_ok_q, priv_refused_q;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  logic [15:0] expq[$];
  logic [15:0] v[13];
  logic [15:0] m;

  csr_regset u_dut (
    .clk(clk),
    .rstn(rstn),
    .wr_en(wr_en),
    .wr_sel(wr_sel),
    .wr_data(wr_data),
    .rd_en(rd_en),
    .rd_sel(rd_sel),
    .ic_ld(ic_ld),
    .ic_next(ic_next),
    .ret_chk(ret_chk),
    .ret_marker(ret_marker),
    .ld_mask(ld_mask),
    .stack_head_in(stack_head_in),
    .priv_req(priv_req),
    .call_req(call_req),
    .call_label_unc(call_label_unc),
    .ind_we(ind_we),
    .ovf_in(ovf_in),
    .carry_in(carry_in),
    .cc_in(cc_in),
    .rstk_set(rstk_set),
    .rstk_clr(rstk_clr),
    .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q),
    .ic_q(ic_q),
    .status_q(status_q),
    .irq_grp_en_q(irq_grp_en_q),
    .bounds_viol_q(bounds_viol_q),
    .priv_ok_q(priv_ok_q),
    .priv_refused_q(priv_refused_q)
  );
  always #20 clk = ~clk;

  // ====================================
  // Shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Pulse a strobe; ev is {violation, granted, refused}
  task automatic op(ref logic s, input logic [2:0] ev);
    s = 1;
    @(negedge clk);
    s = 0;
    chk({13'h0, bounds_viol_q, priv_ok_q, priv_refused_q}, {13'h0, ev});
    // Idle cycle so the next strobe is not set in the same step
    @(negedge clk);
  endtask
  task automatic wr(input logic [3:0] s, input logic [15:0] d, input logic e);
    wr_sel = s;
    wr_data = d;
    op(wr_en, {e, 2'b00});
  endtask
  task automatic rd(input logic [3:0] s, input logic [15:0] e);
    rd_sel = s;
    expq.push_back(e);
    rd_en = 1;
    @(negedge clk);
    rd_en = 0;
    @(negedge clk);
  endtask
  task automatic ic(input logic [15:0] n, input logic e, input logic [15:0] q);
    ic_next = n;
    op(ic_ld, {e, 2'b00});
    chk(ic_q, q);
  endtask

  // ====================================
  // Read monitor and hang guard
  always @(negedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      close_out;
    end else if (rd_valid_q === 1'b1) begin
      chk(rd_data_q, expq.pop_front());
    end
  end

  // ====================================
  // Scenarios
  initial begin
    void'($urandom(32'h18AC));
    repeat (6) @(negedge clk);
    rstn = 1;
    // Descending so ceiling exists before memory top
    v = '{16'h0100, 16'h0000, 16'h01FF, 16'($urandom), 16'h1000, 16'h1100,
      16'h1800, 16'h0003, 16'h2000, 16'($urandom), 16'h8000, 16'($urandom),
      16'h1803};
    for (int i = 11; i >= 0; i--)
      if (i != 1) wr(i[3:0], v[i], 1'b0);
    for (int i = 0; i < 13; i++)
      if (i != 1) rd(i[3:0], v[i]);
    rd(4'hD, 16'h0000);
    wr(`CSR_SEL_CACHED, 16'h0005, 1'b0);
    rd(`CSR_SEL_CACHED, 16'h0003);
    wr(`CSR_SEL_CACHED, 16'h0004, 1'b0);
    rd(`CSR_SEL_HEAD, 16'h1804);
    ic(16'h01FF, 1'b0, 16'h01FF);
    ic(16'h0200, 1'b1, 16'h01FF);
    ic(16'h00FF, 1'b1, 16'h01FF);
    ic(16'h0100, 1'b0, 16'h0100);
    wr(`CSR_SEL_IC, 16'h0300, 1'b1);
    chk(ic_q, 16'h0100);
    wr(`CSR_SEL_IC, 16'h0180, 1'b0);
    chk(ic_q, 16'h0180);
    wr(`CSR_SEL_SMTOP, 16'h2001, 1'b1);
    rd(`CSR_SEL_SMTOP, 16'h1800);
    wr(`CSR_SEL_SMTOP, 16'h0FFF, 1'b0);
    rd(`CSR_SEL_HEAD, 16'h1003);
    ret_marker = 16'h0F00;
    op(ret_chk, 3'b000);
    ret_marker = 16'h2001;
    op(ret_chk, 3'b100);
    rd(`CSR_SEL_MARKER, 16'h0F00);
    for (int i = 0; i < 3; i++) begin
      {ovf_in, carry_in} = 2'($urandom);
      cc_in = i[1:0];
      m = {4'h8, ovf_in, carry_in, cc_in, 8'h00};
      op(ind_we, 3'b000);
      chk(status_q, m);
    end
    op(rstk_set, 3'b000);
    chk(status_q & 16'h1000, 16'h1000);
    op(rstk_clr, 3'b000);
    chk(status_q & 16'h1000, 16'h0000);
    op(priv_req, 3'b010);
    wr(`CSR_SEL_STATUS, 16'hC000, 1'b0);
    m = 16'($urandom);
    stack_head_in = m;
    op(ld_mask, 3'b010);
    chk(irq_grp_en_q, m);
    rd(`CSR_SEL_MASK, m);
    // Drop to user mode, then try to climb back
    wr(`CSR_SEL_STATUS, 16'h6000, 1'b0);
    wr(`CSR_SEL_STATUS, 16'h8000, 1'b0);
    chk(status_q, 16'h4000);
    op(priv_req, 3'b001);
    call_label_unc = 1;
    op(call_req, 3'b001);
    call_label_unc = 0;
    op(call_req, 3'b010);
    stack_head_in = ~m;
    op(ld_mask, 3'b001);
    chk(irq_grp_en_q, m);
    rd(`CSR_SEL_MASK, m);
    wr(`CSR_SEL_SMTOP, 16'h0FFF, 1'b1);
    ret_marker = 16'h0F00;
    op(ret_chk, 3'b100);
    repeat (2) @(negedge clk);
    chk(16'(expq.size()), 16'h0000);
    close_out;
  end
endmodule
`default_nettype wire
